// *** design/irq_prioritizer.sv ***
// Purpose: CPU interrupt controller: level arbitration and vector steering
// Assumes: Core pulses instr_done, irq_return_instr and accepts irq_take
// Notes: Peripheral request lines are levels on the same clock
// Function
// - Sources normal; one vector promotable high
// - High preempts normal; never the reverse
// - Fixed mode: lowest vector wins
// - Optional software-selected round robin
// - Last acknowledged normal vector ranks last
// - NMI ignores enable, unpreemptable, lowest wins
// - Maskable only when global enable set
// - Acknowledge if priority exceeds running handler
// - Load program counter with vector
// - One instruction between servicings
// - Per-level executing state, not stacked
// - Return restores prior controller state
// - Reset address zero; base select picks table
// - Compact table: vectors 1,2,3
// - Entry takes at least three cycles
// - Jump into handler takes three cycles
// - Multicycle instruction completes first
// - Peripheral flags untouched by acknowledge
// - Halt freezes controller during debug
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
module irq_prioritizer
    import irq_prioritizer_pkg::*;
#(
    parameter int N = 16,
    parameter logic [15:0] APP_START = 16'h0100,
    parameter logic [15:0] VEC_OFFSET = 16'h0002,
    parameter logic [N-1:0] NMI_MASK = 16'h0001
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [N-1:0] irq_req,
    input wire logic global_enable,
    input wire logic instr_done,
    input wire logic irq_return_instr,
    input wire logic debug_halt,
    output logic irq_take,
    output logic [7:0] irq_vector,
    output logic [15:0] irq_pc,
    output logic entry_busy,
    output logic [15:0] reset_pc
);
    // Vector numbers are 8 bits wide and vector 0 is the reset vector
    if (N < 2 || N > 255) begin : g_bad_n
        $error("N must lie in 2..255");
    end

    localparam int IW = $clog2(N);
    localparam int ENTRY_W = $clog2(ENTRY_CYCLES + JUMP_CYCLES + 1);
    localparam logic [ENTRY_W-1:0] ENTRY_TOTAL = ENTRY_W'(ENTRY_CYCLES + JUMP_CYCLES);

    typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_GAP} seq_e;

    seq_e seq_q;
    logic [ENTRY_W-1:0] cnt_q;
    logic base_sel_q, compact_q, rotate_q;
    logic [7:0] last_ack_q, high_vec_q;
    logic nmi_ex_q, high_ex_q, normal_ex_q;
    logic [7:0] rdata_q, vec_q;
    logic take_q;
    logic [15:0] pc_q;

    // Request classes
    logic [N-1:0] nmi_req, high_req, normal_req;
    always_comb begin
        nmi_req = irq_req & NMI_MASK;
        high_req = '0;
        normal_req = '0;
        for (int i = 0; i < N; i++) begin
            if (!NMI_MASK[i] && irq_req[i]) begin
                if (high_vec_q == 8'(i + 1)) begin
                    high_req[i] = 1'b1;
                end else begin
                    normal_req[i] = 1'b1;
                end
            end
        end
    end

    // Rotation start is the vector after the last acknowledged one
    logic [IW-1:0] rot_start;
    always_comb begin
        rot_start = '0;
        if (rotate_q && last_ack_q != 8'h00 && int'(last_ack_q) <= N) begin
            rot_start = IW'(int'(last_ack_q) % N);
        end
    end

    logic nmi_found, normal_found;
    logic [IW-1:0] nmi_idx, normal_idx;

    lowest_vector_pick #(.N(N)) u_pick_nmi (
        .req(nmi_req),
        .start('0),
        .found(nmi_found),
        .index(nmi_idx)
    );

    lowest_vector_pick #(.N(N)) u_pick_normal (
        .req(normal_req),
        .start(rot_start),
        .found(normal_found),
        .index(normal_idx)
    );

    // Winner and its level
    logic [1:0] win_lvl, run_lvl;
    logic [7:0] win_vec;
    always_comb begin
        win_lvl = LVL_NONE;
        win_vec = 8'h00;
        if (nmi_found) begin
            win_lvl = LVL_NMI;
            win_vec = 8'(nmi_idx) + 8'h01;
        end else if (global_enable && |high_req) begin
            win_lvl = LVL_HIGH;
            win_vec = high_vec_q;
        end else if (global_enable && normal_found) begin
            win_lvl = LVL_NORMAL;
            win_vec = 8'(normal_idx) + 8'h01;
        end
    end

    always_comb begin
        if (nmi_ex_q) begin
            run_lvl = LVL_NMI;
        end else if (high_ex_q) begin
            run_lvl = LVL_HIGH;
        end else if (normal_ex_q) begin
            run_lvl = LVL_NORMAL;
        end else begin
            run_lvl = LVL_NONE;
        end
    end

    // Strictly higher than the running handler; pending otherwise
    logic accept;
    assign accept = (win_lvl > run_lvl) && seq_q == ST_RUN && instr_done
                    && !irq_return_instr && !debug_halt;

    // Vector placement
    logic [7:0] table_vec;
    logic [15:0] table_base;
    always_comb begin
        table_vec = win_vec;
        if (compact_q) begin
            unique case (win_lvl)
                LVL_NMI: table_vec = COMPACT_NMI_VEC;
                LVL_HIGH: table_vec = COMPACT_HIGH_VEC;
                default: table_vec = COMPACT_NORMAL_VEC;
            endcase
        end
        table_base = base_sel_q ? VEC_OFFSET : APP_START + VEC_OFFSET;
    end

    // Entry sequence: gap of one instruction after each servicing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= ST_RUN;
            cnt_q <= '0;
        end else if (!debug_halt) begin
            unique case (seq_q)
                ST_RUN: begin
                    if (accept) begin
                        seq_q <= ST_ENTRY;
                        cnt_q <= ENTRY_TOTAL - ENTRY_W'(1);
                    end
                end
                ST_ENTRY: begin
                    if (cnt_q == '0) begin
                        seq_q <= ST_GAP;
                    end else begin
                        cnt_q <= cnt_q - ENTRY_W'(1);
                    end
                end
                ST_GAP: begin
                    if (instr_done) begin
                        seq_q <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Acknowledge outputs; request lines are never cleared here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            take_q <= 1'b0;
            vec_q <= 8'h00;
            pc_q <= RESET_ADDR;
        end else begin
            take_q <= accept;
            if (accept) begin
                vec_q <= win_vec;
                pc_q <= table_base + 16'(table_vec);
            end
        end
    end

    // Executing-level flags; lower flags stay set under preemption
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_ex_q <= 1'b0;
            high_ex_q <= 1'b0;
            normal_ex_q <= 1'b0;
        end else if (!debug_halt) begin
            if (accept) begin
                unique case (win_lvl)
                    LVL_NMI: nmi_ex_q <= 1'b1;
                    LVL_HIGH: high_ex_q <= 1'b1;
                    default: normal_ex_q <= 1'b1;
                endcase
            end else if (irq_return_instr) begin
                // Clear only the topmost level; others were set earlier
                if (nmi_ex_q) begin
                    nmi_ex_q <= 1'b0;
                end else if (high_ex_q) begin
                    high_ex_q <= 1'b0;
                end else begin
                    normal_ex_q <= 1'b0;
                end
            end
        end
    end

    // Register writes; last acknowledged vector tracks rotation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_sel_q <= CTRLA_RESET[CTRL_BASE_BIT];
            compact_q <= CTRLA_RESET[CTRL_COMPACT_BIT];
            rotate_q <= CTRLA_RESET[CTRL_ROTATE_BIT];
            high_vec_q <= HIGH_VEC_RESET;
            last_ack_q <= LAST_ACK_RESET;
        end else begin
            if (wr && addr == CTRLA_OFS) begin
                base_sel_q <= wdata[CTRL_BASE_BIT];
                compact_q <= wdata[CTRL_COMPACT_BIT];
                rotate_q <= wdata[CTRL_ROTATE_BIT];
            end
            if (wr && addr == HIGH_VEC_OFS) begin
                high_vec_q <= wdata;
            end
            // Hardware capture wins over a software write in the same cycle
            if (accept && win_lvl == LVL_NORMAL && rotate_q) begin
                last_ack_q <= win_vec;
            end else if (wr && addr == LAST_ACK_OFS) begin
                last_ack_q <= wdata;
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                CTRLA_OFS: rdata_q <= 8'((32'(base_sel_q) << CTRL_BASE_BIT)
                    | (32'(compact_q) << CTRL_COMPACT_BIT) | (32'(rotate_q) << CTRL_ROTATE_BIT));
                STATUS_OFS: rdata_q <= 8'((32'(nmi_ex_q) << STAT_NMI_BIT)
                    | (32'(high_ex_q) << STAT_HIGH_BIT) | (32'(normal_ex_q) << STAT_NORMAL_BIT));
                LAST_ACK_OFS: rdata_q <= last_ack_q;
                HIGH_VEC_OFS: rdata_q <= high_vec_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    logic busy_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= accept || (seq_q == ST_ENTRY && cnt_q != '0);
        end
    end

    assign rdata = rdata_q;
    assign irq_take = take_q;
    assign irq_vector = vec_q;
    assign irq_pc = pc_q;
    assign entry_busy = busy_q;
    // Reset address is constant in both base settings
    logic [15:0] reset_pc_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pc_q <= RESET_ADDR;
        end else begin
            reset_pc_q <= RESET_ADDR;
        end
    end
    assign reset_pc = reset_pc_q;
endmodule : irq_prioritizer

// *** design/lowest_vector_pick.sv ***
// Purpose: Picks the lowest-numbered request at or after a start position
// Assumes: Request bit i stands for vector i+1
// Notes: Wraps around, so a start of 0 gives plain lowest-vector order
`timescale 1ns/1ns
module lowest_vector_pick
    import irq_prioritizer_pkg::*;
#(
    parameter int N = 8
) (
    input wire logic [N-1:0] req,
    input wire logic [$clog2(N)-1:0] start,
    output logic found,
    output logic [$clog2(N)-1:0] index
);
    always_comb begin
        int k;
        k = 0;
        found = 1'b0;
        index = '0;
        for (int i = 0; i < N; i++) begin
            k = (int'(start) + i) % N;
            if (!found && req[k]) begin
                found = 1'b1;
                index = k[$clog2(N)-1:0];
            end
        end
    end
endmodule : lowest_vector_pick

// *** shared/irq_prioritizer_pkg.sv ***
// Purpose: Shared constants for the interrupt prioritizer
// Assumes: 8-bit register port, vectors numbered 1..N (0 is the reset vector)
// Notes: Offsets are the byte offsets of the control/status registers
package irq_prioritizer_pkg;
    localparam logic [7:0] CTRLA_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h01;
    localparam logic [7:0] LAST_ACK_OFS = 8'h02;
    localparam logic [7:0] HIGH_VEC_OFS = 8'h03;
    localparam int CTRL_BASE_BIT = 6;
    localparam int CTRL_COMPACT_BIT = 5;
    localparam int CTRL_ROTATE_BIT = 0;
    localparam int STAT_NMI_BIT = 7;
    localparam int STAT_HIGH_BIT = 1;
    localparam int STAT_NORMAL_BIT = 0;
    localparam logic [7:0] CTRLA_RESET = 8'h00;
    localparam logic [7:0] LAST_ACK_RESET = 8'h00;
    localparam logic [7:0] HIGH_VEC_RESET = 8'h00;
    localparam logic [15:0] RESET_ADDR = 16'h0000;
    localparam logic [7:0] COMPACT_NMI_VEC = 8'h01;
    localparam logic [7:0] COMPACT_HIGH_VEC = 8'h02;
    localparam logic [7:0] COMPACT_NORMAL_VEC = 8'h03;
    localparam int ENTRY_CYCLES = 3;
    localparam int JUMP_CYCLES = 3;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_NORMAL = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_NMI = 2'h3;
endpackage : irq_prioritizer_pkg

// *** test/core_model.sv ***
// Purpose: Processor core stand-in retiring one instruction per cycle
// Assumes: Entry sequence is signalled by irq_take and entry_busy
// Notes: Returns only when the bench asks, as handler software would
`timescale 1ns/1ns
module core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic ret_req,
    input wire logic irq_take,
    input wire logic entry_busy,
    output logic instr_done,
    output logic irq_return_instr
);
    // Nothing retires while the vector is pushed and fetched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= run && !irq_take && !entry_busy;
        end
    end
    // Handlers leave by the interrupt return, never a plain return
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_return_instr <= 1'b0;
        end else begin
            irq_return_instr <= ret_req && !irq_return_instr;
        end
    end
endmodule : core_model

// *** test/irq_prioritizer_bench.sv ***
// Purpose: Directed bench for the interrupt prioritizer
// Assumes: Default table parameters, vector i+1 on request bit i
// Notes: Request lines stand for peripheral flags already enabled
`timescale 1ns/1ns
module irq_prioritizer_bench;
    import irq_prioritizer_pkg::*;
    localparam logic [15:0] APP = 16'h0100;
    localparam logic [15:0] VOFS = 16'h0002;
    localparam logic [15:0] BASE = APP + VOFS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] irq_req = 16'h0000;
    logic global_enable = 1'b1;
    logic debug_halt = 1'b0;
    logic run = 1'b0;
    logic ret_req = 1'b0;
    logic [7:0] rdata, irq_vector;
    logic [15:0] irq_pc, reset_pc;
    logic irq_take, entry_busy, instr_done, irq_return_instr;
    int num_errors = 0;
    int n_tests = 0;
    irq_prioritizer #(.N(16), .APP_START(APP), .VEC_OFFSET(VOFS)) irq_prioritizer_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq_req(irq_req), .global_enable(global_enable),
        .instr_done(instr_done), .irq_return_instr(irq_return_instr),
        .debug_halt(debug_halt), .irq_take(irq_take), .irq_vector(irq_vector),
        .irq_pc(irq_pc), .entry_busy(entry_busy), .reset_pc(reset_pc));
    core_model core_model_i (.clk(clk), .rst_n(rst_n), .run(run), .ret_req(ret_req),
        .irq_take(irq_take), .entry_busy(entry_busy), .instr_done(instr_done),
        .irq_return_instr(irq_return_instr));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
    endtask : rd_check
    task automatic set_req(input logic [15:0] v);
        @(posedge clk);
        irq_req <= v;
    endtask : set_req
    task automatic no_take(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            check("irq_take", 16'h0000, {15'h0000, irq_take});
        end
    endtask : no_take
    task automatic take(input logic [7:0] vec, input logic [15:0] pc);
        // Step off the edge so a pulse launched at this edge is not missed
        #1;
        for (int i = 0; i < 40 && irq_take !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (irq_take !== 1'b1) begin
            num_errors++;
            $display("BAD irq_take expected 1 seen %b", irq_take);
            test_done();
        end else begin
            check("irq_vector", {8'h00, vec}, {8'h00, irq_vector});
            check("irq_pc", pc, irq_pc);
            repeat (8) @(posedge clk);
        end
    endtask : take
    task automatic ret();
        @(posedge clk);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : ret
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_check(CTRLA_OFS, CTRLA_RESET);
        rd_check(STATUS_OFS, 8'h00);
        rd_check(LAST_ACK_OFS, LAST_ACK_RESET);
        rd_check(HIGH_VEC_OFS, HIGH_VEC_RESET);
        rd_check(8'h10, 8'h00);
        check("reset_pc", 16'h0000, reset_pc);
        wr_reg(HIGH_VEC_OFS, 8'h06);
        wr_reg(STATUS_OFS, 8'hFF);
        rd_check(STATUS_OFS, 8'h00);
        rd_check(HIGH_VEC_OFS, 8'h06);
        @(posedge clk);
        run <= 1'b1;
        debug_halt <= 1'b1;
        set_req(16'h0008);
        no_take(10);
        @(posedge clk);
        debug_halt <= 1'b0;
        take(8'h04, BASE + 16'h0004);
        rd_check(STATUS_OFS, 8'h01);
        set_req(16'h0028);
        take(8'h06, BASE + 16'h0006);
        rd_check(STATUS_OFS, 8'h03);
        no_take(10);
        set_req(16'h0008);
        ret();
        rd_check(STATUS_OFS, 8'h01);
        no_take(5);
        set_req(16'h0000);
        ret();
        rd_check(STATUS_OFS, 8'h00);
        @(posedge clk);
        global_enable <= 1'b0;
        set_req(16'h0008);
        no_take(10);
        set_req(16'h0029);
        take(8'h01, BASE + 16'h0001);
        rd_check(STATUS_OFS, 8'h80);
        // Enabled high and normal requests must still wait behind the NMI handler
        @(posedge clk);
        global_enable <= 1'b1;
        no_take(10);
        set_req(16'h0000);
        ret();
        global_enable <= 1'b1;
        wr_reg(CTRLA_OFS, 8'h60);
        set_req(16'h0008);
        take(8'h04, VOFS + 16'h0003);
        set_req(16'h0020);
        take(8'h06, VOFS + 16'h0002);
        set_req(16'h0000);
        ret();
        ret();
        wr_reg(CTRLA_OFS, 8'h01);
        set_req(16'h0014);
        take(8'h03, BASE + 16'h0003);
        rd_check(LAST_ACK_OFS, 8'h03);
        ret();
        take(8'h05, BASE + 16'h0005);
        set_req(16'h0000);
        ret();
        rd_check(STATUS_OFS, 8'h00);
        test_done();
    end
endmodule : irq_prioritizer_bench

// *** test/irq_prioritizer_chk.sv ***
// Purpose: Port-level assertions for the interrupt prioritizer
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ns
module irq_prioritizer_chk
    import irq_prioritizer_pkg::*;
#(
    parameter int N = 16,
    parameter logic [N-1:0] NMI_MASK = 16'h0001
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] irq_req,
    input wire logic global_enable,
    input wire logic instr_done,
    input wire logic debug_halt,
    input wire logic irq_take,
    input wire logic [7:0] irq_vector,
    input wire logic [15:0] irq_pc,
    input wire logic entry_busy,
    input wire logic [15:0] reset_pc
);
    logic [N-1:0] req_q;
    // Request lines as seen at the deciding edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
        end else begin
            req_q <= irq_req;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_take_gap: assert property (irq_take |=> !irq_take [*5])
        else $error("acknowledge repeated inside the entry sequence");
    chk_entry_span: assert property (irq_take |-> entry_busy [*6])
        else $error("entry sequence shorter than six cycles");
    chk_done_first: assert property (irq_take |-> $past(instr_done))
        else $error("acknowledge without a completed instruction");
    chk_halt_holds: assert property (irq_take |-> !$past(debug_halt))
        else $error("acknowledge while the core is halted");
    chk_mask_gate: assert property (irq_take && !$past(global_enable)
        |-> NMI_MASK[irq_vector - 8'h01])
        else $error("maskable request taken with interrupts disabled");
    chk_winner_req: assert property (irq_take |-> req_q[irq_vector - 8'h01])
        else $error("vector taken without its request");
    chk_pc_stands: assert property (!irq_take |-> $stable(irq_pc))
        else $error("target address moved without an acknowledge");
    chk_reset_addr: assert property (reset_pc == RESET_ADDR)
        else $error("reset address not zero");
    cover property (irq_take && !$past(global_enable));
    cover property (irq_take && irq_vector == 8'h06);
    cover property (debug_halt && |irq_req);
endmodule : irq_prioritizer_chk
bind irq_prioritizer irq_prioritizer_chk #(.N(N), .NMI_MASK(NMI_MASK)) irq_prioritizer_chk_i (
    .clk(clk), .rst_n(rst_n), .irq_req(irq_req), .global_enable(global_enable),
    .instr_done(instr_done), .debug_halt(debug_halt), .irq_take(irq_take),
    .irq_vector(irq_vector), .irq_pc(irq_pc), .entry_busy(entry_busy), .reset_pc(reset_pc));
